// >>> hw/clock_gen_mode_sequencer.sv
// Mode sequencer and channel configuration for the four-channel clock generator
`timescale 1ns/1ps
`default_nettype none
module clock_gen_mode_sequencer
  import clkseq_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output var  logic [31:0] HRDATA,
  output var  logic        HREADYOUT,
  output var  logic        HRESP,
  // Strap and control pins
  input  wire logic        REF_SOURCE_SELECT,
  input  wire logic        SERIAL_DATA_PIN,
  input  wire logic        BUS_CLOCK_POWERDOWN_PIN,
  input  wire logic        MIXED_MODE_PIN,
  input  wire logic [1:0]  CH1_FREQ_SELECT,
  input  wire logic [1:0]  CH2_FREQ_SELECT,
  input  wire logic [1:0]  CH3_FREQ_SELECT,
  input  wire logic [1:0]  CH4_SELECT_FIRST,
  input  wire logic [1:0]  CH4_SELECT_SECOND,
  input  wire logic        PLL_STABLE,
  // Reference and power control
  output var  logic        XTAL_OSC_EN,
  output var  logic        EXT_REF_BUF_EN,
  output var  logic        REGULATOR_EN,
  output var  logic        REF_BYPASS,
  output var  logic [3:0]  BUS_ADDR_SEL,
  // Channel control
  output var  logic [3:0]  CH_RUN,
  output var  logic [3:0]  CH_DIFF,
  output var  logic [15:0] CH_FREQ,
  output var  logic        CH4_FRACTIONAL,
  output var  logic [3:0]  CH_STATIC_TRUE,
  output var  logic [3:0]  CH_STATIC_COMP
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    seq_state_t             st;
    logic                   strap_exit;
    logic                   bus_mode;
    logic                   mmc;
    logic [9:0]             sel;
    logic [3:0][HOLD_W-1:0] hold;
    logic [1:0]             ctrl;
    logic [11:0]            chcfg;
    logic [15:0]            chfreq;
    logic                   ph_wr;
    logic [7:0]             ph_addr;
    logic [31:0]            rdata;
    logic                   rdy;
    logic                   osc_en;
    logic                   ext_en;
    logic                   reg_en;
    logic                   bypass;
    logic [3:0]             addr_sel;
    logic [3:0]             run;
    logic [3:0]             diff;
    logic [15:0]            freq;
    logic                   frac;
    logic [3:0]             st_true;
    logic [3:0]             st_comp;
  } seq_t;

  seq_t q_ff;
  seq_t nxt_q;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [14:0] pins_s;
  logic        sda;
  logic        pd;
  logic        mmc_p;
  logic        pll;
  logic        refsel;
  logic [9:0]  cur_sel;

  pin_sync #(.W(15)) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .d     ({CH4_SELECT_SECOND, CH4_SELECT_FIRST, CH3_FREQ_SELECT, CH2_FREQ_SELECT,
             CH1_FREQ_SELECT, REF_SOURCE_SELECT, PLL_STABLE, MIXED_MODE_PIN,
             BUS_CLOCK_POWERDOWN_PIN, SERIAL_DATA_PIN}),
    .q     (pins_s)
  );

  assign sda     = pins_s[0];
  assign pd      = pins_s[1];
  assign mmc_p   = pins_s[2];
  assign pll     = pins_s[3];
  assign refsel  = pins_s[4];
  assign cur_sel = pins_s[14:5];

  // ****************************************
  // Decode tables
  // ****************************************
  // Unresolved code reads as mid, the floating default
  function automatic logic [1:0] lvl(input logic [1:0] c);
    lvl = (c == LVL_LOW || c == LVL_HIGH) ? c : LVL_MID;
  endfunction

  // Returns {diff, freq} for channels one to three
  function automatic logic [4:0] dec123(input int unsigned ch, input logic [1:0] c);
    logic [1:0] v;
    v = lvl(c);
    dec123 = {1'b0, FQ_33_33};
    case (ch)
      0: dec123 = (v == LVL_LOW) ? {1'b0, FQ_50} :
                  (v == LVL_HIGH) ? {1'b0, FQ_25} : {1'b0, FQ_33_33};
      1: dec123 = (v == LVL_LOW) ? {1'b1, FQ_156_25} :
                  (v == LVL_HIGH) ? {1'b1, FQ_125} : {1'b1, FQ_25};
      2: dec123 = (v == LVL_LOW) ? {1'b1, FQ_156_25} :
                  (v == LVL_HIGH) ? {1'b1, FQ_100} : {1'b0, FQ_125};
      default: dec123 = {1'b0, FQ_33_33};
    endcase
  endfunction

  // Returns {fractional, diff, freq} for channel four
  function automatic logic [5:0] dec4(input logic [1:0] a, input logic [1:0] b);
    case ({lvl(a), lvl(b)})
      {LVL_LOW,  LVL_LOW}:  dec4 = {2'b00, FQ_33_33};
      {LVL_LOW,  LVL_MID}:  dec4 = {2'b10, FQ_66_66};
      {LVL_LOW,  LVL_HIGH}: dec4 = {2'b10, FQ_133_33};
      {LVL_MID,  LVL_LOW}:  dec4 = {2'b11, FQ_155_52};
      {LVL_MID,  LVL_HIGH}: dec4 = {2'b01, FQ_125};
      {LVL_HIGH, LVL_LOW}:  dec4 = {2'b11, FQ_106_25};
      {LVL_HIGH, LVL_MID}:  dec4 = {2'b00, FQ_100};
      {LVL_HIGH, LVL_HIGH}: dec4 = {2'b11, FQ_161_13};
      default:              dec4 = {2'b01, FQ_156_25};
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic       take;
  logic [4:0] d123;
  logic [5:0] d4;
  logic       ch_diff;
  logic [3:0] ch_freq;
  logic       ch_run;
  logic       ch_off;
  logic       prog;
  logic       allow;
  logic       loaded;
  logic [1:0] ch_sel;

  assign take = HSEL & HTRANS[1] & HREADY;

  always_comb begin
    nxt_q = q_ff;
    d123 = '0;
    d4 = '0;
    ch_diff = 1'b0;
    ch_freq = '0;
    ch_run = 1'b0;
    ch_off = 1'b0;
    prog = 1'b0;
    allow = 1'b0;
    ch_sel = '0;
    loaded = q_ff.ctrl[CTRL_LOAD_BIT];
    nxt_q.rdy = 1'b1;

    // Bus data phase; narrow writes are dropped
    if (q_ff.ph_wr) begin
      case (q_ff.ph_addr)
        OFS_CTRL:   nxt_q.ctrl = HWDATA[1:0];
        OFS_CHCFG:  nxt_q.chcfg = HWDATA[11:0];
        OFS_CHFREQ: nxt_q.chfreq = HWDATA[15:0];
        default:    nxt_q.ctrl = q_ff.ctrl;
      endcase
    end
    nxt_q.ph_wr = take & HWRITE & (HSIZE == 3'h2);
    nxt_q.ph_addr = HADDR[7:0];
    nxt_q.rdata = '0;
    if (take && !HWRITE) begin
      case (HADDR[7:0])
        OFS_CTRL:   nxt_q.rdata[1:0] = q_ff.ctrl;
        OFS_CHCFG:  nxt_q.rdata[11:0] = q_ff.chcfg;
        OFS_CHFREQ: nxt_q.rdata[15:0] = q_ff.chfreq;
        OFS_STATUS: begin
          nxt_q.rdata[STS_RUN_LSB +: 4] = q_ff.run;
          nxt_q.rdata[STS_PLL_BIT] = pll;
          nxt_q.rdata[STS_BUS_BIT] = q_ff.bus_mode;
          nxt_q.rdata[STS_EXIT_BIT] = q_ff.strap_exit;
          nxt_q.rdata[STS_ST_LSB +: 2] = q_ff.st;
          nxt_q.rdata[STS_SEL_LSB +: 10] = q_ff.sel;
        end
        default:    nxt_q.rdata = '0;
      endcase
    end

    // Sequencer
    case (q_ff.st)
      ST_POR: begin
        nxt_q.sel = cur_sel;
        nxt_q.bus_mode = sda | q_ff.strap_exit;
        nxt_q.st = ST_WAIT_PLL;
      end
      ST_WAIT_PLL: begin
        if (!q_ff.bus_mode) begin
          nxt_q.sel = cur_sel;
        end
        if (pll) begin
          nxt_q.st = ST_RUN;
          if (q_ff.bus_mode) begin
            nxt_q.mmc = mmc_p;
          end
        end
      end
      ST_RUN: begin
        // Losing lock re-enters the wait with outputs static
        if (!pll) begin
          nxt_q.st = ST_WAIT_PLL;
        end
        if (!q_ff.bus_mode) begin
          for (int i = 0; i < 4; i++) begin
            if (q_ff.hold[i] != '0) begin
              nxt_q.hold[i] = q_ff.hold[i] - HOLD_W'(1);
            end
          end
          for (int i = 0; i < 3; i++) begin
            if (cur_sel[2*i +: 2] != q_ff.sel[2*i +: 2]) begin
              nxt_q.sel[2*i +: 2] = cur_sel[2*i +: 2];
              nxt_q.hold[i] = HOLD_LOAD;
            end
          end
          if (cur_sel[9:6] != q_ff.sel[9:6]) begin
            nxt_q.sel[9:6] = cur_sel[9:6];
            nxt_q.hold[3] = HOLD_LOAD;
          end
        end
      end
      ST_PDOWN: begin
        nxt_q.ctrl = CTRL_RST;
        nxt_q.chcfg = CHCFG_RST;
        nxt_q.chfreq = CHFREQ_RST;
        nxt_q.hold = '0;
        nxt_q.mmc = 1'b0;
        if (!pd) begin
          nxt_q.st = ST_POR;
        end
      end
      default: nxt_q.st = ST_POR;
    endcase

    // Data seen high leaves strap mode for good
    if (!q_ff.bus_mode && q_ff.st != ST_POR && sda) begin
      nxt_q.strap_exit = 1'b1;
      nxt_q.bus_mode = 1'b1;
    end
    if (!q_ff.bus_mode && q_ff.st != ST_POR && !sda && pd) begin
      nxt_q.st = ST_PDOWN;
    end
    // Bus mode keeps power-up selections; later pin moves are ignored
    if (q_ff.bus_mode) begin
      nxt_q.sel = (q_ff.st == ST_POR) ? cur_sel : nxt_q.sel;
    end

    // Channel outputs
    for (int i = 0; i < 4; i++) begin
      if (i < 3) begin
        ch_sel = q_ff.sel[2*i +: 2];
        d123 = dec123(i, ch_sel);
        ch_diff = d123[4];
        ch_freq = d123[3:0];
      end else begin
        d4 = dec4(q_ff.sel[7:6], q_ff.sel[9:8]);
        ch_diff = d4[4];
        ch_freq = d4[3:0];
        nxt_q.frac = d4[5];
      end
      ch_off = 1'b0;
      if (q_ff.bus_mode) begin
        prog = loaded & q_ff.chcfg[CFG_PROG_LSB + i];
        if (!q_ff.mmc) begin
          allow = 1'b0;
        end else if (lvl(q_ff.sel[7:6]) == LVL_LOW) begin
          allow = (i == 3);
        end else begin
          allow = (i < 3);
        end
        if (prog) begin
          ch_diff = q_ff.chcfg[CFG_DIFF_LSB + i];
          ch_freq = q_ff.chfreq[4*i +: 4];
          ch_run = q_ff.chcfg[CFG_EN_LSB + i];
          ch_off = ~q_ff.chcfg[CFG_EN_LSB + i];
        end else begin
          ch_run = loaded | allow;
        end
        if (i == 0 && loaded && q_ff.ctrl[CTRL_BYPASS_BIT]) begin
          ch_freq = FQ_REF;
        end
      end else begin
        ch_run = (q_ff.hold[i] == '0);
      end
      ch_run = ch_run & pll & (q_ff.st == ST_RUN);
      nxt_q.run[i] = ch_run;
      nxt_q.diff[i] = ch_diff;
      nxt_q.freq[4*i +: 4] = ch_freq;
      nxt_q.st_true[i] = 1'b0;
      // Static levels are differential idle except a disabled CMOS channel or in power-down, where both sides are low
      nxt_q.st_comp[i] = ~ch_run & ~(ch_off & ~ch_diff) & (q_ff.st != ST_PDOWN);
    end

    nxt_q.reg_en = (q_ff.st != ST_PDOWN);
    nxt_q.osc_en = ~refsel & (q_ff.st != ST_PDOWN);
    nxt_q.ext_en = refsel & (q_ff.st != ST_PDOWN);
    nxt_q.bypass = q_ff.bus_mode & loaded & q_ff.ctrl[CTRL_BYPASS_BIT];
    nxt_q.addr_sel = (q_ff.bus_mode && !q_ff.mmc) ? q_ff.sel[9:6] : 4'h0;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign HRDATA         = q_ff.rdata;
  assign HREADYOUT      = q_ff.rdy;
  assign HRESP          = 1'b0;
  assign XTAL_OSC_EN    = q_ff.osc_en;
  assign EXT_REF_BUF_EN = q_ff.ext_en;
  assign REGULATOR_EN   = q_ff.reg_en;
  assign REF_BYPASS     = q_ff.bypass;
  assign BUS_ADDR_SEL   = q_ff.addr_sel;
  assign CH_RUN         = q_ff.run;
  assign CH_DIFF        = q_ff.diff;
  assign CH_FREQ        = q_ff.freq;
  assign CH4_FRACTIONAL = q_ff.frac;
  assign CH_STATIC_TRUE = q_ff.st_true;
  assign CH_STATIC_COMP = q_ff.st_comp;
endmodule
`default_nettype wire

// >>> hw/pin_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// >>> pkg/clkseq_pkg.sv
// Constants and types for the clock generator mode sequencer
// How it works
// - Reference select low runs 25 MHz crystal oscillator.
// - Select high uses external true/complement buffer.
// - Bus bypass routes reference to channel one.
// - Preload selects, hold outputs static until PLL.
// - Strap mode applies selections once PLL stable.
// - Data high leaves strap mode until power cycle.
// - Strap mode ignores mixed-mode pin.
// - Select change briefly holds that channel static.
// - Strap mode, data low, powerdown high: full power-down.
// - Leaving power-down restarts from power-up.
// - Channels one to three three-level decode.
// - Channel four two-pin decode table.
// - Bus mode freezes select pins after power-up.
// - Mixed pin low: all static, address from ch4.
// - Mixed high, ch4 first low: only ch4 runs.
// - Mixed high, ch4 first mid/high: ch1-3 run.
// - Register load releases static outputs.
// - Unprogrammed channel uses its select pins.
// - Power cycle clears bus registers.
// - Disabled CMOS both low, differential low/high.
package clkseq_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned STATIC_HOLD_NS  = 200;
  localparam int unsigned STATIC_HOLD_CYC = (STATIC_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_W          = 8;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(STATIC_HOLD_CYC);
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CHCFG  = 8'h04;
  localparam logic [7:0] OFS_CHFREQ = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int unsigned CTRL_LOAD_BIT   = 0;
  localparam int unsigned CTRL_BYPASS_BIT = 1;
  localparam int unsigned CFG_PROG_LSB    = 0;
  localparam int unsigned CFG_EN_LSB      = 4;
  localparam int unsigned CFG_DIFF_LSB    = 8;
  localparam int unsigned STS_RUN_LSB     = 0;
  localparam int unsigned STS_PLL_BIT     = 4;
  localparam int unsigned STS_BUS_BIT     = 5;
  localparam int unsigned STS_EXIT_BIT    = 6;
  localparam int unsigned STS_ST_LSB      = 8;
  localparam int unsigned STS_SEL_LSB     = 16;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [11:0] CHCFG_RST  = 12'h000;
  localparam logic [15:0] CHFREQ_RST = 16'h0000;
  // ****************************************
  // Pin levels and frequency codes
  // ****************************************
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [3:0] FQ_REF    = 4'h0;
  localparam logic [3:0] FQ_25     = 4'h1;
  localparam logic [3:0] FQ_33_33  = 4'h2;
  localparam logic [3:0] FQ_50     = 4'h3;
  localparam logic [3:0] FQ_66_66  = 4'h4;
  localparam logic [3:0] FQ_100    = 4'h5;
  localparam logic [3:0] FQ_106_25 = 4'h6;
  localparam logic [3:0] FQ_125    = 4'h7;
  localparam logic [3:0] FQ_133_33 = 4'h8;
  localparam logic [3:0] FQ_155_52 = 4'h9;
  localparam logic [3:0] FQ_156_25 = 4'hA;
  localparam logic [3:0] FQ_161_13 = 4'hB;
  typedef enum logic [1:0] {ST_POR, ST_WAIT_PLL, ST_RUN, ST_PDOWN} seq_state_t;
endpackage

// >>> verification/clkseq_props.sv
// Checker for the clock sequencer's pin and channel outputs
`timescale 1ns/1ps
`default_nettype none
module clkseq_props
  import clkseq_pkg::*;
(
  // Clock, reset and pins
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        PLL_STABLE,
  input  wire logic        REF_SOURCE_SELECT,
  input  wire logic        SERIAL_DATA_PIN,
  input  wire logic        BUS_CLOCK_POWERDOWN_PIN,
  // Outputs watched
  input  wire logic        REGULATOR_EN,
  input  wire logic        XTAL_OSC_EN,
  input  wire logic        EXT_REF_BUF_EN,
  input  wire logic        REF_BYPASS,
  input  wire logic [3:0]  CH_RUN,
  input  wire logic [15:0] CH_FREQ,
  input  wire logic [3:0]  CH_STATIC_TRUE,
  input  wire logic [3:0]  CH_STATIC_COMP
);
  // ****************************************
  // Properties
  // ****************************************
  logic sda_seen_ff;
  logic nxt_sda_seen;
  // Tracked in reset too: a high there picks bus mode, where the pin is a bus clock
  always_comb nxt_sda_seen = SERIAL_DATA_PIN | (RESETN & sda_seen_ff);
  always_ff @(posedge SYS_CLK) sda_seen_ff <= nxt_sda_seen;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  property p_static_until_pll; (PLL_STABLE == 1'b0) [*5] |-> CH_RUN == 4'h0; endproperty
  a_static_until_pll: assert property (p_static_until_pll)
    else $error("channel running without stable pll");
  property p_true_low; CH_STATIC_TRUE == 4'h0; endproperty
  a_true_low: assert property (p_true_low)
    else $error("static true side not low");
  property p_run_not_static; (CH_RUN & CH_STATIC_COMP) == 4'h0; endproperty
  a_run_not_static: assert property (p_run_not_static)
    else $error("running channel held static");
  property p_pdown_quiet; !REGULATOR_EN |-> CH_RUN == 4'h0; endproperty
  a_pdown_quiet: assert property (p_pdown_quiet)
    else $error("channel running in power-down");
  property p_crystal_ref;
    (!REF_SOURCE_SELECT && REGULATOR_EN) [*4] |-> XTAL_OSC_EN && !EXT_REF_BUF_EN; endproperty
  a_crystal_ref: assert property (p_crystal_ref)
    else $error("crystal oscillator not selected");
  property p_ext_ref;
    (REF_SOURCE_SELECT && REGULATOR_EN) [*4] |-> EXT_REF_BUF_EN && !XTAL_OSC_EN; endproperty
  a_ext_ref: assert property (p_ext_ref)
    else $error("external reference buffer not selected");
  property p_bypass_code; REF_BYPASS |-> CH_FREQ[3:0] == FQ_REF; endproperty
  a_bypass_code: assert property (p_bypass_code)
    else $error("bypass without reference code on channel one");
  property p_restart_static; $rose(REGULATOR_EN) |-> (CH_RUN == 4'h0) [*3]; endproperty
  a_restart_static: assert property (p_restart_static)
    else $error("channel running right after power-up");
  property p_pd_enter;
    (!sda_seen_ff && !SERIAL_DATA_PIN && BUS_CLOCK_POWERDOWN_PIN) [*3] |-> ##[1:5] !REGULATOR_EN;
  endproperty
  a_pd_enter: assert property (p_pd_enter)
    else $error("power-down pin did not switch regulators off");
endmodule
`default_nettype wire

// >>> verification/clock_gen_mode_sequencer_bench.sv
// Testbench for the clock generator mode sequencer
`timescale 1ns/1ps
`default_nettype none
module clock_gen_mode_sequencer_bench
  import clkseq_pkg::*;
;
  localparam logic [3:0] F1 [3] = '{FQ_50, FQ_33_33, FQ_25};
  localparam logic [3:0] F2 [3] = '{FQ_156_25, FQ_25, FQ_125};
  localparam logic [3:0] F3 [3] = '{FQ_156_25, FQ_125, FQ_100};
  localparam logic [3:0] F4 [9] = '{FQ_33_33, FQ_66_66, FQ_133_33, FQ_155_52, FQ_156_25,
                                    FQ_125, FQ_106_25, FQ_100, FQ_161_13};
  localparam logic [8:0] D4 = 9'b1_0111_1000;
  localparam logic [8:0] R4 = 9'b1_0100_1110;
  localparam logic [1:0] B4 [3] = '{2'd1, 2'd0, 2'd2};
  localparam logic [3:0] BR [3] = '{4'h0, 4'h8, 4'h7};
  logic sys_clk, resetn, hsel, hwrite, hreadyout, hresp, xtal_en, ext_en, reg_en, bypass, frac;
  logic sda, pd, mmc, rsel, pll;
  logic [1:0] htrans, s1, s2, s3, s4a, s4b;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] addr_sel, run, diff, st_true, st_comp;
  logic [15:0] freq;
  int num_errors = 0;
  int compares = 0;
  clock_gen_mode_sequencer DUT (.SYS_CLK(sys_clk), .RESETN(resetn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .REF_SOURCE_SELECT(rsel), .SERIAL_DATA_PIN(sda), .BUS_CLOCK_POWERDOWN_PIN(pd),
    .MIXED_MODE_PIN(mmc), .CH1_FREQ_SELECT(s1), .CH2_FREQ_SELECT(s2), .CH3_FREQ_SELECT(s3),
    .CH4_SELECT_FIRST(s4a), .CH4_SELECT_SECOND(s4b), .PLL_STABLE(pll), .XTAL_OSC_EN(xtal_en),
    .EXT_REF_BUF_EN(ext_en), .REGULATOR_EN(reg_en), .REF_BYPASS(bypass),
    .BUS_ADDR_SEL(addr_sel), .CH_RUN(run), .CH_DIFF(diff), .CH_FREQ(freq),
    .CH4_FRACTIONAL(frac), .CH_STATIC_TRUE(st_true), .CH_STATIC_COMP(st_comp));
  strap_board brd (.sys_clk(sys_clk), .regulator_en(reg_en), .serial_data_pin(sda),
    .bus_clock_powerdown_pin(pd), .mixed_mode_pin(mmc), .ref_source_select(rsel),
    .ch1_freq_select(s1), .ch2_freq_select(s2), .ch3_freq_select(s3),
    .ch4_select_first(s4a), .ch4_select_second(s4b), .pll_stable(pll));
  always #5 sys_clk = ~sys_clk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    $display("unexpected at %0t: wait timed out", $time);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Slave never stalls today, but the wait stays open up to a bound
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) hang();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0000_00, a};
    hwrite <= wr;
    hsize <= 3'b010;
    bus_wait();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    bus_wait();
    q = hrdata;
    chk(32'(hresp), 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e);
  endtask
  task automatic settle(input logic [3:0] e);
    int n;
    n = 0;
    while (run !== e && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (run !== e) hang();
    chk(32'(run), 32'(e));
  endtask
  // Outputs must sit static before the lock comes
  task automatic power_up;
    @(posedge sys_clk);
    resetn <= 1'b0;
    cycles(20);
    resetn <= 1'b1;
    cycles(7);
    chk(32'({run, st_comp, st_true}), 32'h0000_00F0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {sys_clk, resetn, hsel, hwrite, htrans, hsize} = 9'h000;
    {haddr, hwdata} = 64'h0;
    for (int i = 0; i < 9; i++) begin
      brd.drive(1'b0, 1'b0, 1'b0, 1'b0, 2'(i % 3), 2'(i % 3), 2'(i % 3), 2'(i / 3), 2'(i % 3));
      power_up();
      settle(4'hF);
      chk(32'(freq), 32'({F4[i], F3[i % 3], F2[i % 3], F1[i % 3]}));
      chk(32'(diff), 32'({D4[i], i % 3 != 1, 2'b10}));
      chk(32'(frac), 32'(R4[i]));
    end
    brd.drive(1'b0, 1'b0, 1'b0, 1'b0, 2'd0, 2'd2, 2'd2, 2'd2, 2'd2);
    cycles(6);
    chk(32'(run), 32'h0000_000E);
    settle(4'hF);
    chk(32'(freq[3:0]), 32'(FQ_50));
    brd.drive(1'b0, 1'b0, 1'b1, 1'b1, 2'd0, 2'd2, 2'd2, 2'd2, 2'd2);
    cycles(8);
    chk(32'(run), 32'h0000_000F);
    chk(32'({ext_en, xtal_en}), 32'h0000_0002);
    brd.lock_cyc = 10;
    brd.drive(1'b0, 1'b1, 1'b1, 1'b1, 2'd0, 2'd2, 2'd2, 2'd2, 2'd2);
    cycles(8);
    chk(32'({reg_en, run, st_comp}), 32'h0000_0000);
    brd.drive(1'b0, 1'b0, 1'b1, 1'b1, 2'd0, 2'd2, 2'd2, 2'd2, 2'd2);
    cycles(7);
    chk(32'({run, st_comp}), 32'h0000_000F);
    settle(4'hF);
    brd.drive(1'b1, 1'b0, 1'b1, 1'b1, 2'd0, 2'd2, 2'd2, 2'd2, 2'd2);
    cycles(2);
    brd.drive(1'b0, 1'b1, 1'b1, 1'b1, 2'd0, 2'd2, 2'd2, 2'd2, 2'd2);
    cycles(8);
    chk(32'(reg_en), 32'h0000_0001);
    rd(OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
    for (int c = 0; c < 3; c++) begin
      brd.drive(1'b1, 1'b1, c != 0, 1'b0, 2'd1, 2'd1, 2'd1, B4[c], 2'd2);
      power_up();
      cycles(60);
      chk(32'(run), 32'(BR[c]));
      chk(32'(addr_sel), (c == 0) ? 32'h0000_0009 : 32'h0000_0000);
    end
    brd.drive(1'b1, 1'b1, 1'b1, 1'b0, 2'd0, 2'd0, 2'd0, 2'd2, 2'd2);
    cycles(30);
    chk(32'({run, freq[11:0]}), 32'({4'h7, F3[1], F2[1], F1[1]}));
    wr(OFS_CHCFG, 32'h0000_088A);
    wr(OFS_CHFREQ, 32'h0000_7000);
    wr(OFS_CTRL, 32'h0000_0003);
    settle(4'hD);
    chk(32'({bypass, freq[15:8], freq[3:0]}), 32'({1'b1, FQ_125, F3[1], FQ_REF}));
    chk(32'({st_comp[1], diff[3]}), 32'h0000_0001);
    rd(OFS_CHCFG, 32'hFFFF_FFFF, 32'h0000_088A);
    rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    brd.drive(1'b0, 1'b0, 1'b0, 1'b0, 2'd1, 2'd1, 2'd1, 2'd1, 2'd1);
    power_up();
    rd(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(OFS_CHCFG, 32'hFFFF_FFFF, 32'h0000_0000);
    stop_test();
  end
endmodule
bind clock_gen_mode_sequencer clkseq_props u_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .PLL_STABLE(PLL_STABLE), .REF_SOURCE_SELECT(REF_SOURCE_SELECT),
  .SERIAL_DATA_PIN(SERIAL_DATA_PIN), .BUS_CLOCK_POWERDOWN_PIN(BUS_CLOCK_POWERDOWN_PIN),
  .REGULATOR_EN(REGULATOR_EN), .XTAL_OSC_EN(XTAL_OSC_EN), .EXT_REF_BUF_EN(EXT_REF_BUF_EN),
  .REF_BYPASS(REF_BYPASS), .CH_RUN(CH_RUN), .CH_FREQ(CH_FREQ),
  .CH_STATIC_TRUE(CH_STATIC_TRUE), .CH_STATIC_COMP(CH_STATIC_COMP));
`default_nettype wire

// >>> verification/strap_board.sv
// Board model: strap pins, bus pins at rest and the PLL lock indication
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  // Clock and power
  input  wire logic       sys_clk,
  input  wire logic       regulator_en,
  // Pins
  output var  logic       serial_data_pin,
  output var  logic       bus_clock_powerdown_pin,
  output var  logic       mixed_mode_pin,
  output var  logic       ref_source_select,
  output var  logic [1:0] ch1_freq_select,
  output var  logic [1:0] ch2_freq_select,
  output var  logic [1:0] ch3_freq_select,
  output var  logic [1:0] ch4_select_first,
  output var  logic [1:0] ch4_select_second,
  output var  logic       pll_stable
);
  // ****************************************
  // Pins and lock
  // ****************************************
  int lock_cyc = 30;
  int lock_cnt = 0;
  initial begin
    {serial_data_pin, bus_clock_powerdown_pin, mixed_mode_pin, ref_source_select} = 4'h0;
    {ch1_freq_select, ch2_freq_select, ch3_freq_select} = 6'h00;
    {ch4_select_first, ch4_select_second} = 4'h0;
  end
  // Whole pin set moves together, right after an edge
  task automatic drive(input logic sda, pd, mmc, rsel, input logic [1:0] s1, s2, s3, s4a, s4b);
    @(posedge sys_clk);
    serial_data_pin <= sda;
    bus_clock_powerdown_pin <= pd;
    mixed_mode_pin <= mmc;
    ref_source_select <= rsel;
    ch1_freq_select <= s1;
    ch2_freq_select <= s2;
    ch3_freq_select <= s3;
    ch4_select_first <= s4a;
    ch4_select_second <= s4b;
  endtask
  // Lock needs time after the regulators come up; lost at once when they go
  always @(posedge sys_clk) begin
    if (!regulator_en) begin
      lock_cnt <= 0;
    end else if (lock_cnt < lock_cyc) begin
      lock_cnt <= lock_cnt + 1;
    end
    pll_stable <= regulator_en && lock_cnt >= lock_cyc;
  end
endmodule
`default_nettype wire
